/* File: spg_defines.svh */
// constants for the stack pointer limit guard
// assumes a 16-bit, byte-addressed data space
// Functional notes
// - the stack pointer always addresses the first free word and the stack grows upward.
// - a push writes at the pointer then increments it; a pop decrements first then reads.
// - a call pushes the low 15 bits of the program counter with the word's top bit forced clear.
// - an exception push joins the low status byte onto the counter's top part.
// - the stack limit register takes no value from any reset.
// - bit 0 of the stack pointer is always zero; bit 0 of the stack limit is zero once the limit has been loaded.
// - only push addresses formed through the stack pointer are compared with the limit; pop and indirect addresses are not.
// - a push at pointer equal to limit does not trap; the next push does.
// - a stack pointer address below 0x0800 raises an underflow stack error.
`ifndef SPG_DEFINES_SVH
`define SPG_DEFINES_SVH
`define SPG_SFR_TOP      16'h0800
`define SPG_SP_RESET     16'h0800
`define SPG_WORD_STEP    16'h0002
`define SPG_ALIGN_BIT    0
`endif

/* File: spg_pkg.sv */
// types for the stack pointer limit guard
// assumes spg_defines.svh is included by users
package spg_pkg;
   typedef enum logic [2:0] {
      SPG_OP_NONE,
      SPG_OP_PUSH,
      SPG_OP_POP,
      SPG_OP_CALL,
      SPG_OP_EXC,
      SPG_OP_IND
   } spg_op_t;

   typedef struct packed {
      logic [15:0] addr;
      logic [15:0] wdata;
      logic        wr;
      logic        rd;
      logic        valid;
   } spg_mem_req_t;
endpackage

/* File: spg_bound_chk.sv */
// bound checker for stack addresses
// assumes a combinational use inside the guard
`timescale 1ns/100ps
`include "spg_defines.svh"
module spg_bound_chk (
   input  wire logic [15:0] ea,
   input  wire logic [15:0] limit,
   input  wire logic        is_push,
   output logic             over,
   output logic             under
);
   // unsigned compare; push at ea==limit stays legal
   always_comb begin
      over  = is_push && (ea > limit);
      under = (ea < `SPG_SFR_TOP);
   end
endmodule

/* File: spg_stack_guard.sv */
// stack pointer, push/pop sequencing and stack error trap
// assumes core issues one stack op per cycle, synchronous inputs
`timescale 1ns/100ps
`include "spg_defines.svh"
module spg_stack_guard (
   input  wire logic                 sys_clk,
   input  wire logic                 rst_b,
   input  wire spg_pkg::spg_op_t     op,
   input  wire logic [15:0]          op_data,
   input  wire logic [22:0]          pc,
   input  wire logic [7:0]           status_low_byte,
   input  wire logic                 sp_wr,
   input  wire logic [15:0]          sp_wdata,
   input  wire logic                 lim_wr,
   input  wire logic [15:0]          lim_wdata,
   input  wire logic [15:0]          ind_offset,
   output spg_pkg::spg_mem_req_t     mem_req,
   output logic [15:0]               stack_pointer_reg,
   output logic [15:0]               stack_limit_reg,
   output logic                      stack_trap
);
   logic [15:0] ea;
   logic [15:0] push_word;
   logic [15:0] next_sp;
   logic        is_push;
   logic        uses_sp;
   logic        over;
   logic        under;

   function automatic logic [15:0] spg_align(input logic [15:0] v);
      spg_align = {v[15:1], 1'b0};
   endfunction

   // reads through the pointer: pop and indirect
   function automatic logic spg_is_read(input spg_pkg::spg_op_t o);
      spg_is_read = (o == spg_pkg::SPG_OP_POP) || (o == spg_pkg::SPG_OP_IND);
   endfunction

   assign is_push = (op == spg_pkg::SPG_OP_PUSH) || (op == spg_pkg::SPG_OP_CALL) ||
                    (op == spg_pkg::SPG_OP_EXC);
   assign uses_sp = is_push || spg_is_read(op);

   always_comb begin
      ea = stack_pointer_reg;
      next_sp = stack_pointer_reg;
      push_word = op_data;
      case (op)
         spg_pkg::SPG_OP_PUSH: begin
            next_sp = stack_pointer_reg + `SPG_WORD_STEP;
         end
         spg_pkg::SPG_OP_CALL: begin
            push_word = {1'b0, pc[14:0]};
            next_sp = stack_pointer_reg + `SPG_WORD_STEP;
         end
         spg_pkg::SPG_OP_EXC: begin
            push_word = {status_low_byte, pc[22:15]};
            next_sp = stack_pointer_reg + `SPG_WORD_STEP;
         end
         spg_pkg::SPG_OP_POP: begin
            ea = stack_pointer_reg - `SPG_WORD_STEP;
            next_sp = ea;
         end
         spg_pkg::SPG_OP_IND: begin
            ea = spg_align(stack_pointer_reg + ind_offset);
         end
         default: begin
         end
      endcase
      if (sp_wr) begin
         next_sp = sp_wdata;
      end
   end

   spg_bound_chk u_chk (
      .ea      (ea),
      .limit   (stack_limit_reg),
      .is_push (is_push),
      .over    (over),
      .under   (under)
   );

   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         stack_pointer_reg <= `SPG_SP_RESET;
      end else begin
         stack_pointer_reg <= spg_align(next_sp);
      end
   end

   // no reset on purpose: software must load it before use
   always_ff @(posedge sys_clk) begin
      if (lim_wr) begin
         stack_limit_reg <= spg_align(lim_wdata);
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         mem_req <= '0;
      end else begin
         mem_req.valid <= uses_sp;
         mem_req.addr  <= ea;
         mem_req.wr    <= is_push;
         mem_req.rd    <= spg_is_read(op);
         mem_req.wdata <= push_word;
      end
   end

   // trap registered with the access it belongs to
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         stack_trap <= 1'b0;
      end else begin
         stack_trap <= uses_sp && (over || under);
      end
   end

   // limit is unknown until loaded, so limit checks only follow a load
   a_push_incr: assert property (
      @(posedge sys_clk) disable iff (!rst_b)
      (op == spg_pkg::SPG_OP_PUSH && !sp_wr) |=>
      stack_pointer_reg == $past(stack_pointer_reg) + `SPG_WORD_STEP)
      else $error("push did not advance pointer");

   a_pop_decr: assert property (
      @(posedge sys_clk) disable iff (!rst_b)
      (op == spg_pkg::SPG_OP_POP && !sp_wr) |=>
      stack_pointer_reg == $past(stack_pointer_reg) - `SPG_WORD_STEP &&
      mem_req.addr == stack_pointer_reg)
      else $error("pop address wrong");

   a_push_addr: assert property (
      @(posedge sys_clk) disable iff (!rst_b)
      (op == spg_pkg::SPG_OP_PUSH) |=>
      mem_req.wr && mem_req.addr == $past(stack_pointer_reg))
      else $error("push address wrong");

   a_call_msb: assert property (
      @(posedge sys_clk) disable iff (!rst_b)
      (op == spg_pkg::SPG_OP_CALL) |=>
      !mem_req.wdata[15])
      else $error("call msb set");

   a_call_word: assert property (
      @(posedge sys_clk) disable iff (!rst_b)
      (op == spg_pkg::SPG_OP_CALL) |=>
      {8'h00, mem_req.wdata[14:0]} == ($past(pc) & 23'h007fff))
      else $error("call word lost counter bits");

   a_exc_join: assert property (
      @(posedge sys_clk) disable iff (!rst_b)
      (op == spg_pkg::SPG_OP_EXC) |=>
      mem_req.wdata[15:8] == $past(status_low_byte))
      else $error("exception word lacks status");

   a_exc_low: assert property (
      @(posedge sys_clk) disable iff (!rst_b)
      (op == spg_pkg::SPG_OP_EXC) |=>
      {mem_req.wdata[7:0], 15'h0000} == ($past(pc) & 23'h7f8000))
      else $error("exception word lacks counter top");

   a_sp_align: assert property (
      @(posedge sys_clk) disable iff (!rst_b)
      !stack_pointer_reg[0])
      else $error("pointer misaligned");

   a_sp_load: assert property (
      @(posedge sys_clk) disable iff (!rst_b)
      sp_wr |=>
      stack_pointer_reg == ($past(sp_wdata) & 16'hfffe))
      else $error("pointer load wrong");

   a_lim_load: assert property (
      @(posedge sys_clk) disable iff (!rst_b)
      lim_wr |=>
      stack_limit_reg == ($past(lim_wdata) & 16'hfffe))
      else $error("limit load wrong");

   a_push_eq_ok: assert property (
      @(posedge sys_clk) disable iff (!rst_b)
      (op == spg_pkg::SPG_OP_PUSH && stack_pointer_reg == stack_limit_reg &&
       stack_pointer_reg >= `SPG_SFR_TOP) |=> !stack_trap)
      else $error("push at limit trapped");

   a_push_over: assert property (
      @(posedge sys_clk) disable iff (!rst_b)
      (op == spg_pkg::SPG_OP_PUSH && stack_pointer_reg > stack_limit_reg) |=>
      stack_trap)
      else $error("overflow not trapped");

   a_under_trap: assert property (
      @(posedge sys_clk) disable iff (!rst_b)
      (op == spg_pkg::SPG_OP_PUSH && stack_pointer_reg < `SPG_SFR_TOP) |=>
      stack_trap)
      else $error("underflow not trapped");

   a_pop_under: assert property (
      @(posedge sys_clk) disable iff (!rst_b)
      (op == spg_pkg::SPG_OP_POP && stack_pointer_reg >= `SPG_WORD_STEP &&
       stack_pointer_reg <= `SPG_SFR_TOP) |=> stack_trap)
      else $error("pop underflow not trapped");

   a_no_op_quiet: assert property (
      @(posedge sys_clk) disable iff (!rst_b)
      (op == spg_pkg::SPG_OP_NONE) |=>
      !stack_trap && !mem_req.valid)
      else $error("trap without stack access");

   a_trap_access: assert property (
      @(posedge sys_clk) disable iff (!rst_b)
      stack_trap |->
      mem_req.valid)
      else $error("trap outside access cycle");

   a_ind_no_move: assert property (
      @(posedge sys_clk) disable iff (!rst_b)
      (op == spg_pkg::SPG_OP_IND && !sp_wr) |=>
      stack_pointer_reg == $past(stack_pointer_reg))
      else $error("indirect access moved pointer");

   a_ind_read: assert property (
      @(posedge sys_clk) disable iff (!rst_b)
      (op == spg_pkg::SPG_OP_IND) |=>
      mem_req.rd && !mem_req.wr && !mem_req.addr[0])
      else $error("indirect read malformed");
endmodule

/* File: spg_core_model.sv */
// core-side model: exception logic and data memory write port
// assumes mem_req and stack_trap come straight from the guard
`timescale 1ns/100ps
module spg_core_model (
   input  wire logic                  sys_clk,
   input  wire logic                  rst_b,
   input  wire spg_pkg::spg_mem_req_t mem_req,
   input  wire logic                  stack_trap,
   output logic [7:0]                 trap_count,
   output logic [15:0]                last_wdata
);
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         trap_count <= 8'h00;
      end else if (stack_trap) begin
         trap_count <= trap_count + 8'h01;
      end
   end
   // memory keeps its words across reset, like real ram
   always_ff @(posedge sys_clk) begin
      if (mem_req.valid && mem_req.wr) begin
         last_wdata <= mem_req.wdata;
      end
   end
endmodule

/* File: spg_stack_guard_bench.sv */
// self-checking bench for the stack guard
// assumes spg_pkg, the guard and the core model are compiled first
`timescale 1ns/100ps
module spg_stack_guard_bench;
   logic                  sys_clk = 1'b0;
   logic                  rst_b = 1'b0;
   spg_pkg::spg_op_t      op = spg_pkg::SPG_OP_NONE;
   logic [15:0]           op_data = 16'h0000;
   logic [22:0]           pc = 23'h5abcde;
   logic [7:0]            status_low_byte = 8'h3c;
   logic                  sp_wr = 1'b0;
   logic                  lim_wr = 1'b0;
   logic [15:0]           wdata = 16'h0000;
   logic [15:0]           ind_offset = 16'h0000;
   spg_pkg::spg_mem_req_t mem_req;
   logic [15:0]           sp, lim, last_wdata;
   logic                  trap;
   logic [7:0]            trap_count;
   int                    err_total = 0;
   int                    checks_done = 0;
   always #5 sys_clk = ~sys_clk;
   spg_stack_guard i_dut (.sys_clk(sys_clk), .rst_b(rst_b), .op(op), .op_data(op_data),
      .pc(pc), .status_low_byte(status_low_byte), .sp_wr(sp_wr), .sp_wdata(wdata),
      .lim_wr(lim_wr), .lim_wdata(wdata), .ind_offset(ind_offset), .mem_req(mem_req),
      .stack_pointer_reg(sp), .stack_limit_reg(lim), .stack_trap(trap));
   spg_core_model i_core (.sys_clk(sys_clk), .rst_b(rst_b), .mem_req(mem_req),
      .stack_trap(trap), .trap_count(trap_count), .last_wdata(last_wdata));
   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      checks_done++;
      if (seen !== exp) begin
         err_total++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // every task starts and ends 1 ns after a rising edge; drives stand until the next task
   task automatic run(input spg_pkg::spg_op_t o, input logic [15:0] d);
      op = o;
      op_data = d;
      sp_wr = 1'b0;
      lim_wr = 1'b0;
      @(posedge sys_clk);
      #1;
   endtask
   task automatic wr(input logic s, input logic l, input logic [15:0] v);
      op = spg_pkg::SPG_OP_NONE;
      sp_wr = s;
      lim_wr = l;
      wdata = v;
      @(posedge sys_clk);
      #1;
   endtask
   task automatic t_push_limit();
      wr(1'b1, 1'b1, 16'h1233);
      chk({sp, lim}, {16'h1232, 16'h1232});
      wr(1'b1, 1'b0, 16'h1230);
      run(spg_pkg::SPG_OP_PUSH, 16'haaaa);
      chk({mem_req.addr, mem_req.wdata}, 32'h1230aaaa);
      chk({mem_req.wr, mem_req.valid, trap}, 3'b110);
      run(spg_pkg::SPG_OP_PUSH, 16'h5555);
      chk({sp, trap}, {16'h1234, 1'b0});
      run(spg_pkg::SPG_OP_PUSH, 16'h1111);
      chk({mem_req.addr, trap}, {16'h1234, 1'b1});
      run(spg_pkg::SPG_OP_POP, 16'h0000);
      chk({mem_req.addr, mem_req.rd, sp, trap}, {16'h1234, 1'b1, 16'h1234, 1'b0});
      chk(trap_count, 8'h01);
   endtask
   task automatic t_underflow();
      wr(1'b1, 1'b0, 16'h0800);
      run(spg_pkg::SPG_OP_POP, 16'h0000);
      chk({mem_req.addr, sp, trap}, {16'h07fe, 16'h07fe, 1'b1});
      ind_offset = 16'h0004;
      run(spg_pkg::SPG_OP_IND, 16'h0000);
      chk({mem_req.addr, trap}, {16'h0802, 1'b0});
      ind_offset = 16'h0000;
      run(spg_pkg::SPG_OP_IND, 16'h0000);
      chk({mem_req.addr, trap, trap_count}, {16'h07fe, 1'b1, 8'h02});
      run(spg_pkg::SPG_OP_PUSH, 16'h2222);
      chk({mem_req.addr, sp, trap}, {16'h07fe, 16'h0800, 1'b1});
   endtask
   // pc is 23'h5abcde: bit 15 set, so the call word must clear it
   task automatic t_pc_words();
      wr(1'b1, 1'b0, 16'h0900);
      run(spg_pkg::SPG_OP_CALL, 16'h0000);
      chk(mem_req.wdata, 16'h3cde);
      run(spg_pkg::SPG_OP_EXC, 16'h0000);
      chk(mem_req.wdata, 16'h3cb5);
      chk(last_wdata, 16'h3cde);
   endtask
   task automatic t_rereset();
      op = spg_pkg::SPG_OP_NONE;
      rst_b = 1'b0;
      repeat (2) @(posedge sys_clk);
      #1;
      rst_b = 1'b1;
      chk({sp, lim, trap, mem_req.valid}, {16'h0800, 16'h1232, 1'b0, 1'b0});
      run(spg_pkg::SPG_OP_PUSH, 16'h0000);
      chk({mem_req.addr, mem_req.valid, sp, trap}, {16'h0800, 1'b1, 16'h0802, 1'b0});
   endtask
   task automatic tally_and_finish();
      if (err_total == 0 && checks_done > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   initial begin
      #20000;
      err_total++;
      tally_and_finish();
   end
   initial begin
      repeat (12) @(posedge sys_clk);
      #1;
      rst_b = 1'b1;
      chk({sp, trap}, {16'h0800, 1'b0});
      // a limit write is never followed straight by an indirect read
      t_push_limit();
      t_underflow();
      t_pc_words();
      t_rereset();
      tally_and_finish();
   end
endmodule
